// *** hdl/dma_ctrl_pkg.sv ***
/*
  Shared constants, register map and carrier types of the DMA channel
  control block. Assumes 8-bit I/O addresses and byte-wide data.
*/
`default_nettype none
package dma_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_LO_CMD_STS = 8'h08;
  localparam logic [7:0] OFF_LO_SMASK   = 8'h0a;
  localparam logic [7:0] OFF_LO_MODE    = 8'h0b;
  localparam logic [7:0] OFF_HI_CMD_STS = 8'hd0;
  localparam logic [7:0] OFF_HI_SMASK   = 8'hd4;
  localparam logic [7:0] OFF_HI_MODE    = 8'hd6;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CMD_ROT_BIT   = 4;
  localparam int unsigned CMD_DIS_BIT   = 2;
  localparam int unsigned SMASK_SET_BIT = 2;
  localparam int unsigned MODE_LSB      = 2;
  localparam int unsigned COUNT_W       = 16;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] XMODE_DEMAND  = 2'h0;
  localparam logic [1:0] XMODE_SINGLE  = 2'h1;
  localparam logic [1:0] XMODE_CASCADE = 2'h3;
  localparam logic [1:0] XTYPE_VERIFY  = 2'h0;
  localparam logic [1:0] XTYPE_ILLEGAL = 2'h3;
  localparam logic [3:0] MASK_RESET    = 4'hf;
  localparam logic [3:0] TC_RESET      = 4'h0;

  typedef struct packed {
    logic [1:0] xfer_mode;
    logic       decrement;
    logic       autoinit;
    logic [1:0] xfer_type;
  } mode_t;

  typedef struct packed {
    logic [COUNT_W-1:0] addr;
    logic [COUNT_W-1:0] count;
  } chan_base_t;

  typedef struct packed {
    logic [2:0]         chan;
    logic [COUNT_W-1:0] addr;
    logic [1:0]         xfer_type;
    logic               strobe_en;
    logic               decrement;
    logic               last;
  } svc_word_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] idx;
  } pick_t;

  // Fixed: lowest index wins. Rotating: the one after the last winner.
  function automatic pick_t pick4(input logic [3:0] req, input logic [1:0] last,
                                  input logic rot);
    pick_t      p;
    logic [1:0] idx;
    p = '0;
    for (int k = 3; k >= 0; k--) begin
      idx = rot ? 2'(last + 2'(k) + 2'h1) : 2'(k);
      if (req[idx]) begin
        p.valid = 1'b1;
        p.idx   = idx;
      end
    end
    return p;
  endfunction

endpackage
`default_nettype wire

// *** hdl/svc_buffer.sv ***
/*
  Small valid/ready buffer for service words.
  Assumes a single clock; the drain side may stall at will.
*/
`default_nettype none
module svc_buffer #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 cnt;
  } state_t;

  state_t q, d;
  logic   push, pop;

  assign in_ready_o  = (q.cnt != (PW+1)'(DEPTH));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = q.mem[q.rd];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data_i;
      d.wr        = (q.wr == PW'(DEPTH - 1)) ? '0 : PW'(q.wr + 1'b1);
    end
    if (pop) begin
      d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : PW'(q.rd + 1'b1);
    end
    if (push && !pop) begin
      d.cnt = (PW+1)'(q.cnt + 1'b1);
    end else if (pop && !push) begin
      d.cnt = (PW+1)'(q.cnt - 1'b1);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// *** hdl/chan_counter.sv ***
/*
  Per-channel base/current address and count with wrap and reload.
  Assumes step_i is a one-cycle pulse per transfer.
*/
`default_nettype none
module chan_counter #(
  parameter int unsigned CW = 16
) (
  input  wire logic          core_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          load_i,
  input  wire logic [CW-1:0] base_addr_i,
  input  wire logic [CW-1:0] base_count_i,
  input  wire logic          step_i,
  input  wire logic          decr_i,
  input  wire logic          autoinit_i,
  output logic [CW-1:0]      cur_addr_o,
  output logic [CW-1:0]      cur_count_o,
  output logic               zero_o
);
  typedef struct packed {
    logic [CW-1:0] ba;
    logic [CW-1:0] bc;
    logic [CW-1:0] ca;
    logic [CW-1:0] cc;
  } state_t;

  state_t q, d;

  assign cur_addr_o  = q.ca;
  assign cur_count_o = q.cc;
  assign zero_o      = (q.cc == '0);

  always_comb begin
    d = q;
    if (load_i) begin
      d.ba = base_addr_i;
      d.bc = base_count_i;
      d.ca = base_addr_i;
      d.cc = base_count_i;
    end else if (step_i) begin
      if (zero_o && autoinit_i) begin
        d.ca = q.ba;
        d.cc = q.bc;
      end else begin
        // Zero wraps to all ones, which is the terminal count step
        d.cc = CW'(q.cc - 1'b1);
        d.ca = decr_i ? CW'(q.ca - 1'b1) : CW'(q.ca + 1'b1);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// *** hdl/dma_channel_control_regs.sv ***
/*
  Command, status, single-mask and mode logic of a two-group,
  eight-channel DMA controller, with arbitration and a service-word
  stream toward the bus cycle engine.
  Assumes byte I/O strobes on core_clk_i, asynchronous request pins,
  base values loaded by the address/count register logic outside.
*/
`default_nettype none
module dma_channel_control_regs #(
  parameter int unsigned BUF_DEPTH = 2
) (
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic [7:0]                    io_addr_i,
  input  wire logic                          io_wr_i,
  input  wire logic                          io_rd_i,
  input  wire logic [7:0]                    io_wdata_i,
  output logic [7:0]                         io_rdata_o,
  output logic                               io_rvalid_o,
  input  wire logic [7:0]                    channel_request_line_i,
  input  wire logic [7:0]                    sw_request_i,
  input  wire logic [1:0]                    master_clear_i,
  input  wire logic [7:0]                    base_load_i,
  input  wire dma_ctrl_pkg::chan_base_t [7:0] base_i,
  output logic                               svc_valid_o,
  input  wire logic                          svc_ready_i,
  output dma_ctrl_pkg::svc_word_t            svc_word_o,
  output logic [7:0]                         channel_mask_o,
  output dma_ctrl_pkg::mode_t [7:0]          channel_mode_o,
  output logic [7:0]                         terminal_count_o,
  output logic [1:0]                         group_active_o
);
  import dma_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]      sync1;
    logic [7:0]      sync2;
    logic [1:0]      rotate;
    logic [1:0]      disable_grp;
    logic [7:0]      tc_flag;
    logic [7:0]      mask;
    mode_t [7:0]     mode;
    logic [1:0][1:0] last;
    logic [7:0]      rdata;
    logic            rvalid;
    logic [7:0]      tc_pulse;
  } state_t;

  state_t q, d;

  // ----------------------------------------------------------------
  // Request view, arbitration and stepping
  // ----------------------------------------------------------------
  logic [7:0]         req_raw;
  logic [7:0]         req_stat;
  logic [7:0]         eligible;
  logic               lo_en, hi_en;
  pick_t              lo_pick, hi_pick;
  logic [3:0]         hi_req;
  logic [2:0]         win_ch;
  logic               fire;
  logic               buf_ready;
  logic [7:0]         step;
  logic [7:0]         zero;
  logic [7:0]         tc_ev;
  logic [7:0]         sts_lo, sts_hi;
  logic [COUNT_W-1:0] cur_addr [8];
  svc_word_t          word;

  // Only the second stage of the synchroniser is looked at
  assign req_raw  = q.sync2 | sw_request_i;
  assign req_stat = {req_raw[7:5], |req_raw[3:0], req_raw[3:0]};

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // Cascade channels run their own cycles, so no word is issued
      eligible[i] = req_raw[i] & ~q.mask[i] &
                    (q.mode[i].xfer_mode != XMODE_CASCADE);
    end
  end

  assign lo_en   = ~q.disable_grp[0] & ~q.disable_grp[1];
  assign hi_en   = ~q.disable_grp[1];
  assign lo_pick = pick4(eligible[3:0] & {4{lo_en}}, q.last[0], q.rotate[0]);
  // Channel 4 slot stands for the whole lower group
  assign hi_req  = {eligible[7:5], lo_pick.valid & ~q.mask[4]} & {4{hi_en}};
  assign hi_pick = pick4(hi_req, q.last[1], q.rotate[1]);
  assign win_ch  = (hi_pick.idx == 2'h0) ? {1'b0, lo_pick.idx} : {1'b1, hi_pick.idx};
  assign fire    = hi_pick.valid & buf_ready;
  assign step    = fire ? 8'(8'h01 << win_ch) : 8'h00;
  assign tc_ev   = step & zero;

  always_comb begin
    word           = '0;
    word.chan      = win_ch;
    word.addr      = cur_addr[win_ch];
    word.xfer_type = q.mode[win_ch].xfer_type;
    // Verify and illegal types raise no memory or I/O strobe
    word.strobe_en = (q.mode[win_ch].xfer_type != XTYPE_VERIFY) &&
                     (q.mode[win_ch].xfer_type != XTYPE_ILLEGAL);
    word.decrement = q.mode[win_ch].decrement;
    word.last      = zero[win_ch];
  end

  for (genvar g = 0; g < 8; g++) begin : g_chan
    chan_counter #(.CW(COUNT_W)) u_cnt (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .load_i      (base_load_i[g]),
      .base_addr_i (base_i[g].addr),
      .base_count_i(base_i[g].count),
      .step_i      (step[g]),
      .decr_i      (q.mode[g].decrement),
      .autoinit_i  (q.mode[g].autoinit),
      .cur_addr_o  (cur_addr[g]),
      .cur_count_o (),
      .zero_o      (zero[g])
    );
  end

  svc_buffer #(.WIDTH($bits(svc_word_t)), .DEPTH(BUF_DEPTH)) u_buf (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .in_valid_i (hi_pick.valid),
    .in_ready_o (buf_ready),
    .in_data_i  (word),
    .out_valid_o(svc_valid_o),
    .out_ready_i(svc_ready_i),
    .out_data_o (svc_word_o)
  );

  // ----------------------------------------------------------------
  // Register access and next state
  // ----------------------------------------------------------------
  assign sts_lo = {req_stat[3:0], q.tc_flag[3:0]};
  assign sts_hi = {req_stat[7:4], q.tc_flag[7:5], 1'b0};

  always_comb begin
    logic       grp;
    logic [2:0] ch;
    grp        = (io_addr_i[7:4] != 4'h0);
    ch         = {grp, io_wdata_i[1:0]};
    d          = q;
    d.sync1    = channel_request_line_i;
    d.sync2    = q.sync1;
    d.rvalid   = io_rd_i;
    d.tc_pulse = tc_ev;
    if (fire) begin
      d.last[1] = hi_pick.idx;
      if (hi_pick.idx == 2'h0) begin
        d.last[0] = lo_pick.idx;
      end
    end
    if (io_wr_i) begin
      if (io_addr_i == OFF_LO_CMD_STS || io_addr_i == OFF_HI_CMD_STS) begin
        d.rotate[grp]      = io_wdata_i[CMD_ROT_BIT];
        d.disable_grp[grp] = io_wdata_i[CMD_DIS_BIT];
      end
      if (io_addr_i == OFF_LO_SMASK || io_addr_i == OFF_HI_SMASK) begin
        d.mask[ch] = io_wdata_i[SMASK_SET_BIT];
      end
      if (io_addr_i == OFF_LO_MODE || io_addr_i == OFF_HI_MODE) begin
        d.mode[ch] = mode_t'(io_wdata_i[7:MODE_LSB]);
      end
    end
    d.rdata = UNMAPPED_READ;
    if (io_rd_i) begin
      if (io_addr_i == OFF_LO_CMD_STS) begin
        d.rdata          = sts_lo;
        d.tc_flag[3:0]   = TC_RESET;
      end else if (io_addr_i == OFF_HI_CMD_STS) begin
        d.rdata          = sts_hi;
        d.tc_flag[7:4]   = TC_RESET;
      end
    end
    // A terminal count in the read cycle survives the clear
    for (int i = 0; i < 8; i++) begin
      if (tc_ev[i]) begin
        d.tc_flag[i] = (i != 4);
        if (!q.mode[i].autoinit) begin
          d.mask[i] = 1'b1;
        end
      end
    end
    // Master clear resets the group's command, priority, flag, mask and mode state and wins over every other update of it
    for (int g = 0; g < 2; g++) begin
      if (master_clear_i[g]) begin
        d.rotate[g]          = 1'b0;
        d.disable_grp[g]     = 1'b0;
        d.last[g]            = 2'h0;
        d.tc_flag[g*4 +: 4]  = TC_RESET;
        d.mask[g*4 +: 4]     = MASK_RESET;
        for (int c = 0; c < 4; c++) begin
          d.mode[g*4 + c] = '0;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q      <= '0;
      q.mask <= {MASK_RESET, MASK_RESET};
    end else begin
      q <= d;
    end
  end

  assign io_rdata_o       = q.rdata;
  assign io_rvalid_o      = q.rvalid;
  assign channel_mask_o   = q.mask;
  assign channel_mode_o   = q.mode;
  assign terminal_count_o = q.tc_pulse;
  assign group_active_o   = {hi_en, lo_en};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  rotate_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (io_wr_i && io_addr_i == OFF_HI_CMD_STS && !master_clear_i[1])
    |=> (q.rotate[1] == $past(io_wdata_i[CMD_ROT_BIT])))
    else $error("rotate bit not taken from command write");

  group_disable_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    q.disable_grp[0] |-> !(fire && !win_ch[2]))
    else $error("disabled lower group issued a transfer");

  cascade_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (q.disable_grp[1] |-> !fire) and (group_active_o[0] |-> group_active_o[1]))
    else $error("upper group disable did not stop both groups");

  status_req_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (io_rd_i && io_addr_i == OFF_LO_CMD_STS)
    |=> (io_rvalid_o && io_rdata_o[7:4] == $past(q.sync2[3:0] | sw_request_i[3:0])))
    else $error("lower status request bits wrong");

  cascade_status_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (io_rd_i && io_addr_i == OFF_HI_CMD_STS)
    |=> (io_rdata_o[4] == $past(|req_raw[3:0]) && io_rdata_o[0] == 1'b0))
    else $error("channel 4 status not the OR of the lower group");

  tc_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tc_ev[2] && !master_clear_i[0]) |=> (q.tc_flag[2] && terminal_count_o[2]))
    else $error("terminal count flag not set");

  single_mask_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (io_wr_i && io_addr_i == OFF_LO_SMASK && io_wdata_i[1:0] == 2'h1 && !master_clear_i[0]
     && !tc_ev[1]) |=> (q.mask[1] == $past(io_wdata_i[SMASK_SET_BIT])
     && (q.mask[0] == $past(q.mask[0]) || $past(tc_ev[0]))))
    else $error("single mask write touched the wrong channel");

  mode_store_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (io_wr_i && io_addr_i == OFF_HI_MODE && io_wdata_i[1:0] == 2'h2 && !master_clear_i[1])
    |=> (q.mode[6] == $past(io_wdata_i[7:2])))
    else $error("mode bits not stored in selected channel");

  cascade_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    fire |-> (q.mode[win_ch].xfer_mode != XMODE_CASCADE && win_ch != 3'h4))
    else $error("cascade channel issued a transfer word");

  tc_mask_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tc_ev[1] && !q.mode[1].autoinit) |=> q.mask[1])
    else $error("terminal count did not mask the channel");

  master_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    master_clear_i[0] |=> (q.mask[3:0] == MASK_RESET && q.tc_flag[3:0] == TC_RESET
                           && !q.rotate[0] && !q.mode[0].autoinit))
    else $error("master clear did not act as reset");

  high_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    master_clear_i[1] |=> (q.mask[7:4] == MASK_RESET && !q.disable_grp[1]
                           && !q.rotate[1]))
    else $error("upper master clear did not act as reset");

  cmd_disable_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (io_wr_i && io_addr_i == OFF_LO_CMD_STS && !master_clear_i[0])
    |=> (q.disable_grp[0] == $past(io_wdata_i[CMD_DIS_BIT])))
    else $error("group enable bit not taken from command write");

  fixed_prio_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (fire && hi_pick.idx == 2'h0 && !q.rotate[0] && eligible[0])
    |-> (win_ch == 3'h0))
    else $error("fixed priority did not pick the lowest channel");

  mask_block_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    fire |-> !q.mask[win_ch])
    else $error("masked channel issued a transfer");

  // An autoinit channel keeps running, so its mask must not move at terminal count
  autoinit_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tc_ev[2] && q.mode[2].autoinit && !master_clear_i[0]
     && !(io_wr_i && io_addr_i == OFF_LO_SMASK)) |=> (q.mask[2] == $past(q.mask[2])))
    else $error("autoinit channel was masked at terminal count");

  // The mask set at terminal count is what stops the channel; there is no stop flag
  tc_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tc_ev[1] && !q.mode[1].autoinit) |=> !step[1])
    else $error("channel kept running after terminal count");

  tc_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (fire && word.last) |=> (terminal_count_o != 8'h00))
    else $error("last transfer gave no terminal count pulse");

  verify_strobe_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (svc_valid_o && (svc_word_o.xfer_type == XTYPE_VERIFY
                     || svc_word_o.xfer_type == XTYPE_ILLEGAL)) |-> !svc_word_o.strobe_en)
    else $error("verify or illegal word enables strobes");

  rvalid_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (io_rvalid_o == $past(io_rd_i)))
    else $error("read valid is not a pulse one cycle after the read");

  // Write-only and unmapped addresses read as zero so no stale byte leaks out
  unmapped_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (io_rd_i && io_addr_i != OFF_LO_CMD_STS && io_addr_i != OFF_HI_CMD_STS)
    |=> (io_rdata_o == UNMAPPED_READ))
    else $error("non-status read did not return zero");
endmodule
`default_nettype wire

// *** verif/dma_far_side.sv ***
/*
  Far-side model: the memory and I/O end that drains service words.
  Assumes one clock; stall_i comes from the bench at clock edges.
*/
`default_nettype none
module dma_far_side (
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    stall_i,
  input  wire logic                    svc_valid_i,
  input  wire dma_ctrl_pkg::svc_word_t svc_word_i,
  output logic                         svc_ready_o,
  output var int                       n_words_o,
  output dma_ctrl_pkg::svc_word_t      last_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dma_ctrl_pkg::*;
  // ----------------------------------------
  // Drain
  // ----------------------------------------
  // A stall holds ready low for as long as the bench asks, so the buffer fills
  assign svc_ready_o = ~stall_i;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      n_words_o   <= 0;
      last_word_o <= '0;
    end else if (svc_valid_i && svc_ready_o) begin
      n_words_o   <= n_words_o + 1;
      last_word_o <= svc_word_i;
    end
  end
endmodule
`default_nettype wire

// *** verif/dma_channel_control_regs_tb_top.sv ***
/*
  Self-checking bench of the DMA channel control block.
  Assumes the far-side model drains the service stream.
*/
`default_nettype none
module dma_channel_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dma_ctrl_pkg::*;
  logic             core_clk_i = 1'b0;
  logic             rst_n_i    = 1'b0;
  logic             io_wr      = 1'b0;
  logic             io_rd      = 1'b0;
  logic             stall      = 1'b0;
  logic             rvalid;
  logic             svc_valid;
  logic             svc_ready;
  logic [7:0]       io_addr    = '0;
  logic [7:0]       io_wdata   = '0;
  logic [7:0]       req        = '0;
  logic [7:0]       swr        = '0;
  logic [7:0]       bload      = '0;
  logic [7:0]       tc_seen    = '0;
  logic [7:0]       rdata;
  logic [7:0]       mask;
  logic [7:0]       tc;
  logic [1:0]       mclr       = '0;
  logic [1:0]       gact;
  chan_base_t [7:0] base       = '0;
  svc_word_t        word;
  svc_word_t        lw;
  mode_t [7:0]      mode;
  int               n_errors   = 0;
  int               tests_run  = 0;
  int               nw;
  int               save;

  always #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) tc_seen <= tc_seen | tc;

  dma_channel_control_regs u_dma_channel_control_regs (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .io_addr_i(io_addr), .io_wr_i(io_wr),
    .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(rdata), .io_rvalid_o(rvalid),
    .channel_request_line_i(req), .sw_request_i(swr), .master_clear_i(mclr),
    .base_load_i(bload), .base_i(base), .svc_valid_o(svc_valid), .svc_ready_i(svc_ready),
    .svc_word_o(word), .channel_mask_o(mask), .channel_mode_o(mode),
    .terminal_count_o(tc), .group_active_o(gact)
  );
  dma_far_side u_dma_far_side (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .stall_i(stall), .svc_valid_i(svc_valid),
    .svc_word_i(word), .svc_ready_o(svc_ready), .n_words_o(nw), .last_word_o(lw)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test;
    $display("Errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // Reserved bits are always written as zero by every caller
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge core_clk_i);
    io_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge core_clk_i);
    io_rd <= 1'b0;
    #1;
    chk(16'(rvalid), 16'h1);
    chk(16'(rdata), 16'(exp));
  endtask
  task automatic wait_words(input int n);
    for (int i = 0; i < 80; i++) begin
      if (nw >= n) return;
      cyc(1);
    end
    chk(16'(nw), 16'(n));
    finish_test();
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    cyc(1);
    chk(16'(mask), 16'hff);
    chk(16'(mode[1]), 16'h0);
    chk(16'(gact), 16'h3);
    base[0] <= '{addr: 16'h0100, count: 16'h0005};
    base[1] <= '{addr: 16'h1000, count: 16'h0001};
    base[2] <= '{addr: 16'h2000, count: 16'h0000};
    bload   <= 8'h07;
    @(posedge core_clk_i);
    bload <= '0;
    wr(8'h0b, 8'h45);
    chk(16'(mode[1]), 16'h11);
    wr(8'h0a, 8'h01);
    chk(16'(mask), 16'hfd);
    // Channel 4 carries the lower group, so it must be unmasked as well
    wr(8'hd4, 8'h00);
    chk(16'(mask), 16'hed);
    @(posedge core_clk_i);
    req <= 8'h02;
    wait_words(2);
    cyc(4);
    chk(16'(nw), 16'h2);
    chk(16'(lw.last), 16'h1);
    chk(lw.addr, 16'h1001);
    chk(16'(tc_seen[1]), 16'h1);
    chk(16'(mask[1]), 16'h1);
    rd(8'h08, 8'h22);
    rd(8'hd0, 8'h10);
    rd(8'h08, 8'h20);
    // Autoinit channel, drain stalled so the buffer must hold its words
    wr(8'h0b, 8'h56);
    chk(16'(mode[2]), 16'h15);
    wr(8'h0a, 8'h02);
    @(posedge core_clk_i);
    stall <= 1'b1;
    req   <= 8'h04;
    cyc(20);
    chk(16'(svc_valid), 16'h1);
    chk(16'(nw), 16'h2);
    @(posedge core_clk_i);
    stall <= 1'b0;
    wait_words(5);
    @(posedge core_clk_i);
    req <= '0;
    cyc(12);
    chk(16'(svc_valid), 16'h0);
    chk(16'(mask[2]), 16'h0);
    chk(lw.addr, 16'h2000);
    chk(16'(lw.last), 16'h1);
    // Cascade channel issues nothing
    wr(8'h0b, 8'hc7);
    chk(16'(mode[3]), 16'h31);
    wr(8'h0a, 8'h03);
    save = nw;
    @(posedge core_clk_i);
    req <= 8'h08;
    cyc(12);
    chk(16'(nw), 16'(save));
    @(posedge core_clk_i);
    req <= '0;
    // Upper group disable also stops the lower group
    wr(8'h0b, 8'h44);
    wr(8'h0a, 8'h00);
    wr(8'hd0, 8'h04);
    chk(16'(gact), 16'h0);
    cyc(6);
    save = nw;
    @(posedge core_clk_i);
    req <= 8'h01;
    cyc(12);
    chk(16'(nw), 16'(save));
    wr(8'hd0, 8'h00);
    chk(16'(gact), 16'h3);
    wait_words(save + 1);
    chk(16'(lw.chan), 16'h0);
    chk(lw.addr, 16'h0100);
    wr(8'h08, 8'h04);
    chk(16'(gact), 16'h2);
    wr(8'h08, 8'h10);
    chk(16'(gact), 16'h3);
    @(posedge core_clk_i);
    req <= '0;
    // Upper group mode and mask, software request on a verify channel
    wr(8'hd6, 8'hc5);
    chk(16'(mode[5]), 16'h31);
    wr(8'hd4, 8'h02);
    chk(16'(mask[6]), 16'h0);
    wr(8'hd6, 8'h62);
    chk(16'(mode[6]), 16'h18);
    cyc(6);
    save = nw;
    @(posedge core_clk_i);
    swr <= 8'h40;
    cyc(2);
    rd(8'hd0, 8'h44);
    wait_words(save + 1);
    chk(16'(lw.chan), 16'h6);
    chk(16'(lw.strobe_en), 16'h0);
    chk(16'(lw.xfer_type), 16'h0);
    chk(16'(lw.decrement), 16'h1);
    @(posedge core_clk_i);
    swr <= '0;
    rd(8'h0b, 8'h00);
    @(posedge core_clk_i);
    mclr <= 2'b11;
    @(posedge core_clk_i);
    mclr <= '0;
    #1;
    chk(16'(mask), 16'hff);
    chk(16'(mode[1]), 16'h0);
    chk(16'(mode[2]), 16'h0);
    finish_test();
  end
endmodule
`default_nettype wire
